// ### iocfg_params.svh
// offsets, field positions, reset values and timing counts of the io config block
`ifndef IOCFG_PARAMS_SVH
`define IOCFG_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (7-bit serial port address)
// ----------------------------------------------------------------------
`define IOCFG_OFS_GAIN_LEVEL   7'h11
`define IOCFG_OFS_GAIN_UPDATE  7'h12
`define IOCFG_OFS_FORMAT       7'h13
`define IOCFG_OFS_MODE         7'h14
`define IOCFG_OFS_GAIN_STATUS  7'h1f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IOCFG_BIT_FAST_GAIN    4
`define IOCFG_BIT_TX_TWOS      7
`define IOCFG_BIT_RX_TWOS      6
`define IOCFG_BIT_TX_INV_SMP   5
`define IOCFG_BIT_INTERP_HI    1
`define IOCFG_BIT_INTERP_LO    0
`define IOCFG_BIT_LOOPBACK     5
`define IOCFG_BIT_DUPLEX       4
`define IOCFG_BIT_DIRECTION    3
`define IOCFG_BIT_WIDTH        2
`define IOCFG_BIT_DIR_OVR      1
`define IOCFG_BIT_CLONE        0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IOCFG_RST_GAIN_LEVEL   8'hff
`define IOCFG_RST_GAIN_UPDATE  8'h00
`define IOCFG_RST_FORMAT       8'h00
`define IOCFG_RST_MODE         8'h10

// ----------------------------------------------------------------------
// serial frame and timing counts
// ----------------------------------------------------------------------
`define IOCFG_FRAME_BITS       16
`define IOCFG_HDR_BITS         8
`define IOCFG_RAMP_STEP_CYC    4

`endif

// ### iocfg_pkg.sv
// types shared by the io config block
package iocfg_pkg;

    // interface mode presented to the data bus logic
    typedef enum logic [1:0] {
        IOCFG_FULL_DUPLEX_MODE        = 2'b00,
        IOCFG_HALF_DUPLEX_NARROW_MODE = 2'b01,
        IOCFG_HALF_DUPLEX_WIDE_MODE   = 2'b10
    } iocfg_mode_t;

    // transmit interpolation rate
    typedef enum logic [1:0] {
        IOCFG_INTERP_BYPASS = 2'b00,
        IOCFG_INTERP_X2     = 2'b01,
        IOCFG_INTERP_X4     = 2'b10
    } iocfg_interp_t;

endpackage

// ### iocfg_regs.sv
// io interface and transmit path configuration registers with serial port
//
// Summary of operation
// - fast gain bit: jump; else ramp gain
// - tx format straight binary, twos when set
// - rx format straight binary, twos when set
// - tx capture rising edge, falling when set
// - interp field: 00 bypass, 01 2x, 10 4x
// - loop-back: full-duplex timing, tx path out rx
// - duplex bit high full, reset high
// - duplex and width pick mode; clone ignores duplex
// - half duplex: direction bit high means tx
// - width bit high 12-bit, low 24-bit
// - override takes direction from register bit
`timescale 1ns/1ps
`include "iocfg_params.svh"

module iocfg_regs #(
    parameter int RAMP_STEP_CYC = `IOCFG_RAMP_STEP_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_sen_n,
    input  wire logic                  spi_sdio_i,
    output logic                       spi_sdio_o,
    output logic                       spi_sdio_oe,
    input  wire logic                  tx_rx_pin,
    output logic [7:0]                 tx_gain_amplifier,
    output logic                       fast_gain_update,
    output logic                       tx_twos_complement,
    output logic                       rx_twos_complement,
    output logic                       tx_sample_falling,
    output iocfg_pkg::iocfg_interp_t   interp_rate,
    output logic                       loopback_en,
    output iocfg_pkg::iocfg_mode_t     interface_mode,
    output logic                       clone_enable,
    output logic                       tx_direction
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    // the ramp pacing counter is eight bits wide
    if (RAMP_STEP_CYC < 1 || RAMP_STEP_CYC > 255) begin : g_bad_ramp
        $error("RAMP_STEP_CYC must lie in 1..255");
    end

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // undefined encoding 11 falls back to bypass
    function automatic iocfg_pkg::iocfg_interp_t decode_interp(
        input logic [1:0] f
    );
        if (f == 2'b01) begin
            return iocfg_pkg::IOCFG_INTERP_X2;
        end else if (f == 2'b10) begin
            return iocfg_pkg::IOCFG_INTERP_X4;
        end else begin
            return iocfg_pkg::IOCFG_INTERP_BYPASS;
        end
    endfunction

    // true while the counter sits in the eight data bits of a frame
    function automatic logic in_data_phase(
        input logic [4:0] cnt
    );
        return cnt >= 5'(`IOCFG_HDR_BITS) && cnt < 5'(`IOCFG_FRAME_BITS);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sclk_sync_q;
    logic [1:0] sen_sync_q;
    logic [1:0] sdi_sync_q;
    logic [1:0] dir_sync_q;
    logic       sclk_prev_q;

    // two flops on every pin before any logic looks at it
    // enable flops reset high so no frame starts out of reset
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_sync_q <= 2'h0;
            sen_sync_q  <= 2'h3;
            sdi_sync_q  <= 2'h0;
            dir_sync_q  <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], spi_sclk};
            sen_sync_q  <= {sen_sync_q[0], spi_sen_n};
            sdi_sync_q  <= {sdi_sync_q[0], spi_sdio_i};
            dir_sync_q  <= {dir_sync_q[0], tx_rx_pin};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sen_active;

    // edges of the synchronised serial clock
    assign sclk_rise  = sclk_sync_q[1] & ~sclk_prev_q;
    assign sclk_fall  = ~sclk_sync_q[1] & sclk_prev_q;
    assign sen_active = ~sen_sync_q[1];

    // ------------------------------------------------------------------
    // serial frame: read flag, 7-bit address, 8 data bits, msb first
    // ------------------------------------------------------------------
    logic [4:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic       rd_q;
    logic [6:0] addr_q;
    logic [7:0] rd_data_q;
    logic       wr_stb;
    logic [7:0] wr_data;

    // write commits on the 16th rise; a cut frame never reaches it
    assign wr_data = {shift_q, sdi_sync_q[1]};
    assign wr_stb  = sen_active & sclk_rise & ~rd_q
                   & (bit_cnt_q == 5'(`IOCFG_FRAME_BITS - 1));

    // registers holding the configuration
    logic [7:0] gain_level_q;
    logic [7:0] gain_update_q;
    logic [7:0] format_q;
    logic [7:0] mode_q;
    logic [7:0] gain_cur_q;
    logic [7:0] rd_mux;
    logic [6:0] hdr_addr;

    // address as the header completes, before addr_q has loaded it
    assign hdr_addr = {shift_q[5:0], sdi_sync_q[1]};

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (hdr_addr == `IOCFG_OFS_GAIN_LEVEL) begin
            rd_mux = gain_level_q;
        end else if (hdr_addr == `IOCFG_OFS_GAIN_UPDATE) begin
            rd_mux = gain_update_q;
        end else if (hdr_addr == `IOCFG_OFS_FORMAT) begin
            rd_mux = format_q;
        end else if (hdr_addr == `IOCFG_OFS_MODE) begin
            rd_mux = mode_q;
        end else if (hdr_addr == `IOCFG_OFS_GAIN_STATUS) begin
            rd_mux = gain_cur_q;
        end
    end

    // bit counter, header capture, read data load
    always_ff @(posedge clk) begin
        if (rst || !sen_active) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 7'h00;
            rd_q      <= 1'b0;
            addr_q    <= 7'h00;
            rd_data_q <= 8'h00;
        end else if (sclk_rise && bit_cnt_q < 5'(`IOCFG_FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q   <= {shift_q[5:0], sdi_sync_q[1]};
            if (bit_cnt_q == 5'(`IOCFG_HDR_BITS - 1)) begin
                rd_q      <= shift_q[6];
                addr_q    <= hdr_addr;
                rd_data_q <= rd_mux;
            end
        end else if (sclk_fall && rd_q && in_data_phase(bit_cnt_q)) begin
            rd_data_q <= {rd_data_q[6:0], 1'b0};
        end
    end

    // read data driven on falling serial clock during the data phase
    // oe drops after the 16th rise so the host may drive again
    always_ff @(posedge clk) begin
        if (rst || !sen_active) begin
            spi_sdio_o  <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else if (sclk_fall && rd_q && in_data_phase(bit_cnt_q)) begin
            spi_sdio_o  <= rd_data_q[7];
            spi_sdio_oe <= 1'b1;
        end else if (bit_cnt_q == 5'(`IOCFG_FRAME_BITS)) begin
            spi_sdio_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            gain_level_q  <= `IOCFG_RST_GAIN_LEVEL;
            gain_update_q <= `IOCFG_RST_GAIN_UPDATE;
            format_q      <= `IOCFG_RST_FORMAT;
            mode_q        <= `IOCFG_RST_MODE;
        end else if (wr_stb) begin
            if (addr_q == `IOCFG_OFS_GAIN_LEVEL) begin
                gain_level_q <= wr_data;
            end else if (addr_q == `IOCFG_OFS_GAIN_UPDATE) begin
                gain_update_q <= wr_data;
            end else if (addr_q == `IOCFG_OFS_FORMAT) begin
                format_q <= wr_data;
            end else if (addr_q == `IOCFG_OFS_MODE) begin
                mode_q <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // gain amplifier update: jump when fast, else ramp one step per tick
    // ------------------------------------------------------------------
    logic [7:0] ramp_cnt_q;
    logic       ramp_tick;

    assign ramp_tick = (ramp_cnt_q == 8'(RAMP_STEP_CYC - 1));

    // pacing counter for the smooth ramp
    // slow ramp trades settling time for spur-free gain steps
    always_ff @(posedge clk) begin
        if (rst || ramp_tick) begin
            ramp_cnt_q <= 8'h00;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 8'h01;
        end
    end

    // applied gain follows the programmed level
    // the status register reads back this applied value
    always_ff @(posedge clk) begin
        if (rst) begin
            gain_cur_q <= `IOCFG_RST_GAIN_LEVEL;
        end else if (gain_update_q[`IOCFG_BIT_FAST_GAIN]) begin
            gain_cur_q <= gain_level_q;
        end else if (ramp_tick && gain_cur_q < gain_level_q) begin
            gain_cur_q <= gain_cur_q + 8'h01;
        end else if (ramp_tick && gain_cur_q > gain_level_q) begin
            gain_cur_q <= gain_cur_q - 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // decoded configuration outputs, all registered
    // ------------------------------------------------------------------
    iocfg_pkg::iocfg_mode_t mode_d;
    logic                   dir_d;

    // interface mode; clone ignores duplex, loop-back forces full duplex
    // loop-back must see full duplex bus timing
    always_comb begin
        if (mode_q[`IOCFG_BIT_LOOPBACK]) begin
            mode_d = iocfg_pkg::IOCFG_FULL_DUPLEX_MODE;
        end else if (mode_q[`IOCFG_BIT_DUPLEX]
                     && !mode_q[`IOCFG_BIT_CLONE]) begin
            mode_d = iocfg_pkg::IOCFG_FULL_DUPLEX_MODE;
        end else if (mode_q[`IOCFG_BIT_WIDTH]) begin
            mode_d = iocfg_pkg::IOCFG_HALF_DUPLEX_NARROW_MODE;
        end else begin
            mode_d = iocfg_pkg::IOCFG_HALF_DUPLEX_WIDE_MODE;
        end
    end

    // direction: register bit under override, else the pin
    always_comb begin
        if (mode_q[`IOCFG_BIT_DIR_OVR]) begin
            dir_d = mode_q[`IOCFG_BIT_DIRECTION];
        end else begin
            dir_d = dir_sync_q[1];
        end
    end

    // every output straight from a flop, one cycle after its register
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_gain_amplifier  <= `IOCFG_RST_GAIN_LEVEL;
            fast_gain_update   <= 1'b0;
            tx_twos_complement <= 1'b0;
            rx_twos_complement <= 1'b0;
            tx_sample_falling  <= 1'b0;
            interp_rate        <= iocfg_pkg::IOCFG_INTERP_BYPASS;
            loopback_en        <= 1'b0;
            interface_mode     <= iocfg_pkg::IOCFG_FULL_DUPLEX_MODE;
            clone_enable       <= 1'b0;
            tx_direction       <= 1'b0;
        end else begin
            tx_gain_amplifier  <= gain_cur_q;
            fast_gain_update   <= gain_update_q[`IOCFG_BIT_FAST_GAIN];
            tx_twos_complement <= format_q[`IOCFG_BIT_TX_TWOS];
            rx_twos_complement <= format_q[`IOCFG_BIT_RX_TWOS];
            tx_sample_falling  <= format_q[`IOCFG_BIT_TX_INV_SMP];
            interp_rate        <= decode_interp(
                format_q[`IOCFG_BIT_INTERP_HI:`IOCFG_BIT_INTERP_LO]);
            loopback_en        <= mode_q[`IOCFG_BIT_LOOPBACK];
            interface_mode     <= mode_d;
            clone_enable       <= mode_q[`IOCFG_BIT_CLONE];
            tx_direction       <= dir_d;
        end
    end

endmodule

// ### iocfg_spi_host.sv
// serial programming port host model for the io config block
`timescale 1ns/1ps
module iocfg_spi_host #(
    parameter int HALF_CYC = 8
) (
    input  wire logic clk,
    input  wire logic sdio,
    output logic      sclk,
    output logic      sen_n,
    output logic      sdo
);
    // port idle: clock stands low, enable high
    initial begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdo = 1'b0;
    end

    // one frame: rd flag, 7 address bits, 8 data bits, msb first
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        @(posedge clk);
        sen_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (HALF_CYC) @(posedge clk);
            sclk <= 1'b0;
            // released in read data phase: shows the inverse of last bit
            sdo <= (rd && i < 8) ? ~sdo : f[i];
            repeat (HALF_CYC - 1) @(posedge clk);
            #1 q[i % 8] = sdio;
            @(posedge clk);
            sclk <= 1'b1;
        end
        repeat (HALF_CYC) @(posedge clk);
        sclk <= 1'b0;
        sen_n <= 1'b1;
        repeat (HALF_CYC) @(posedge clk);
    endtask
endmodule

// ### iocfg_regs_sva.sv
// port checks for the io config register block
`timescale 1ns/1ps
module iocfg_regs_chk #(
    parameter int RAMP_STEP_CYC = 4
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     spi_sclk,
    input wire logic                     spi_sen_n,
    input wire logic                     spi_sdio_i,
    input wire logic                     spi_sdio_o,
    input wire logic                     spi_sdio_oe,
    input wire logic                     tx_rx_pin,
    input wire logic [7:0]               tx_gain_amplifier,
    input wire logic                     fast_gain_update,
    input wire logic                     tx_twos_complement,
    input wire logic                     rx_twos_complement,
    input wire logic                     tx_sample_falling,
    input wire iocfg_pkg::iocfg_interp_t interp_rate,
    input wire logic                     loopback_en,
    input wire iocfg_pkg::iocfg_mode_t   interface_mode,
    input wire logic                     clone_enable,
    input wire logic                     tx_direction
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_gain_max: assert property (
        $fell(rst) |-> tx_gain_amplifier == 8'hff)
        else $error("gain not at maximum after reset");
    a_ramp_single_step: assert property (
        !fast_gain_update && !$past(fast_gain_update) |->
        (tx_gain_amplifier - $past(tx_gain_amplifier))
            inside {8'h00, 8'h01, 8'hff})
        else $error("gain jumped while ramping");
    a_reset_full_duplex: assert property (
        $fell(rst) |-> interface_mode == 2'h0 && !loopback_en
        && !clone_enable)
        else $error("mode not full duplex after reset");
    a_interp_code_legal: assert property (
        interp_rate != 2'h3)
        else $error("undefined interpolation code shown");
    a_mode_code_legal: assert property (
        interface_mode != 2'h3)
        else $error("undefined interface mode shown");
    a_loopback_full_duplex: assert property (
        loopback_en |-> interface_mode == 2'h0)
        else $error("loop-back without full duplex mode");
    a_clone_ignores_duplex: assert property (
        clone_enable && !loopback_en |-> interface_mode != 2'h0)
        else $error("clone mode followed duplex bit");
    a_config_idle_hold: assert property (
        spi_sen_n [*8] |=> $stable({interp_rate, interface_mode,
        loopback_en, clone_enable, tx_twos_complement,
        rx_twos_complement, tx_sample_falling, fast_gain_update}))
        else $error("config changed with no frame");
endmodule

bind iocfg_regs iocfg_regs_chk #(.RAMP_STEP_CYC(RAMP_STEP_CYC)) chk (
    .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n),
    .spi_sdio_i(spi_sdio_i), .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe), .tx_rx_pin(tx_rx_pin),
    .tx_gain_amplifier(tx_gain_amplifier),
    .fast_gain_update(fast_gain_update),
    .tx_twos_complement(tx_twos_complement),
    .rx_twos_complement(rx_twos_complement),
    .tx_sample_falling(tx_sample_falling), .interp_rate(interp_rate),
    .loopback_en(loopback_en), .interface_mode(interface_mode),
    .clone_enable(clone_enable), .tx_direction(tx_direction));

// ### iocfg_regs_bench.sv
// self-checking bench for the io config register block
`timescale 1ns/1ps
`include "iocfg_params.svh"
module iocfg_regs_bench;
    logic                     clk;
    logic                     rst;
    logic                     sclk;
    logic                     sen_n;
    logic                     host_bit;
    logic                     pin;
    logic                     sdio_o;
    logic                     sdio_oe;
    logic                     fast;
    logic                     txtc;
    logic                     rxtc;
    logic                     smpf;
    logic                     lb;
    logic                     clone;
    logic                     txdir;
    logic [7:0]               gain;
    logic [7:0]               rd;
    logic [7:0]               v;
    logic [31:0]              seed = 32'h0000005e;
    iocfg_pkg::iocfg_interp_t interp;
    iocfg_pkg::iocfg_mode_t   mode;
    int                       fail_count = 0;
    int                       n_compared = 0;
    wire                      sdio = sdio_oe ? sdio_o : host_bit;

    iocfg_regs #(.RAMP_STEP_CYC(1)) uut (
        .clk(clk), .rst(rst), .spi_sclk(sclk), .spi_sen_n(sen_n),
        .spi_sdio_i(sdio), .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe),
        .tx_rx_pin(pin), .tx_gain_amplifier(gain), .fast_gain_update(fast),
        .tx_twos_complement(txtc), .rx_twos_complement(rxtc),
        .tx_sample_falling(smpf), .interp_rate(interp), .loopback_en(lb),
        .interface_mode(mode), .clone_enable(clone), .tx_direction(txdir));

    iocfg_spi_host h (.clk(clk), .sdio(sdio), .sclk(sclk), .sen_n(sen_n),
        .sdo(host_bit));

    // clock only; rst and pin start in the main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // mode from loop-back, clone, duplex and width bits
    function automatic logic [1:0] exp_mode(input logic [7:0] m);
        if (m[5] || (m[4] && !m[0])) return 2'h0;
        return m[2] ? 2'h1 : 2'h2;
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog against a hung frame; the frames need about 44k cycles
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("gain", gain, 8'hff);
        h.xfer(1'b1, `IOCFG_OFS_MODE, 8'h00, rd);
        check("mode reg", rd, 8'h10);
        h.xfer(1'b1, 7'h7e, 8'h00, rd);
        check("unmapped", rd, 8'h00);
        // format register: every interpolation code, then random
        for (int i = 0; i < 12; i++) begin
            v = (rnd() & 8'he0) | ((i < 4) ? i[7:0] : rnd() & 8'h03);
            h.xfer(1'b0, `IOCFG_OFS_FORMAT, v, rd);
            check("tx twos", {7'h0, txtc}, {7'h0, v[7]});
            check("rx twos", {7'h0, rxtc}, {7'h0, v[6]});
            check("falling", {7'h0, smpf}, {7'h0, v[5]});
            check("interp", {6'h0, interp},
                  v[1:0] == 2'h3 ? 8'h0 : v & 8'h3);
            h.xfer(1'b1, `IOCFG_OFS_FORMAT, 8'h00, rd);
            check("format reg", rd, v);
        end
        // every mode bit combination that has duplex set whenever loop-back is set, with a random direction pin
        for (int i = 0; i < 64; i++) begin
            v = i[7:0] | (i[5] ? 8'h10 : 8'h00);
            pin <= ^(rnd() & 8'h01);
            // clone also needs the clock-mode field, held outside this block
            h.xfer(1'b0, `IOCFG_OFS_MODE, v, rd);
            check("mode", {6'h0, mode},
                  {6'h0, exp_mode(v)});
            check("loopback", {7'h0, lb}, {7'h0, v[5]});
            check("clone", {7'h0, clone}, {7'h0, v[0]});
            check("dir", {7'h0, txdir},
                  {7'h0, v[1] ? v[3] : pin});
            h.xfer(1'b1, `IOCFG_OFS_MODE, 8'h00, rd);
            check("mode reg", rd, v);
        end
        // fast update jumps, slow update ramps
        h.xfer(1'b0, `IOCFG_OFS_GAIN_UPDATE, 8'h10, rd);
        check("fast", {7'h0, fast}, 8'h01);
        v = rnd();
        h.xfer(1'b0, `IOCFG_OFS_GAIN_LEVEL, v, rd);
        check("gain fast", gain, v);
        h.xfer(1'b0, `IOCFG_OFS_GAIN_UPDATE, 8'h00, rd);
        h.xfer(1'b0, `IOCFG_OFS_GAIN_LEVEL, v ^ 8'h80, rd);
        check("ramping", {7'h0, gain === (v ^ 8'h80)}, 8'h00);
        repeat (300) @(posedge clk);
        check("gain slow", gain, v ^ 8'h80);
        h.xfer(1'b0, `IOCFG_OFS_GAIN_STATUS, ~v, rd);
        h.xfer(1'b1, `IOCFG_OFS_GAIN_STATUS, 8'h00, rd);
        check("status", rd, v ^ 8'h80);
        end_of_test();
    end
endmodule
